// *** src/daqsp_pkg.sv ***
/*
  Shared constants for the serial register port of the data acquisition converter.
  Assumes a single 20 MHz system clock; pins are sampled by the port module.
*/
package daqsp_pkg;
  // system clock and reset pin timing
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned RST_MIN_NS  = 50;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  ////////////////////////////////////////////////////////////////////////////////
  // register addresses (instruction field is five bits)
  localparam logic [4:0] A_RES_LO = 5'h00;
  localparam logic [4:0] A_RES_HI = 5'h01;
  localparam logic [4:0] A_FAULT  = 5'h02;
  localparam logic [4:0] A_CTL    = 5'h03;
  localparam logic [4:0] A_GMX    = 5'h04;
  localparam logic [4:0] A_PST    = 5'h05;
  localparam logic [4:0] A_DIR    = 5'h06;
  localparam logic [4:0] A_REF    = 5'h07;
  localparam logic [4:0] A_SER    = 5'h18;
  localparam logic [4:0] A_ID     = 5'h1f;
  localparam logic [7:0] REG_RST  = 8'h00;
  // writable bits of each register
  localparam logic [7:0] M_CTL = 8'hef;
  localparam logic [7:0] M_GMX = 8'h7f;
  localparam logic [7:0] M_NIB = 8'h0f;
  localparam logic [7:0] M_REF = 8'h3f;
  ////////////////////////////////////////////////////////////////////////////////
  // instruction byte fields
  localparam int B_DIRECT = 7;
  localparam int B_RD     = 6;
  localparam int B_WIDE   = 5;
  localparam int B_ADR_HI = 4;
  // register fields
  localparam int B_BUSY   = 7;
  localparam int B_BIN    = 5;
  localparam int B_CDF_HI = 1;
  localparam int B_CDF_LO = 0;
  localparam int B_OSC    = 4;
  localparam int B_REFERENCE_ON   = 3;
  localparam int B_REFERENCE_BUFFER_ON   = 2;
  localparam int B_LVL_HI = 1;
  localparam int B_MSB_LO = 6;
  localparam int B_OVR    = 0;
  // serial config keeps each option twice, mirrored about the byte centre
  localparam int B_LSB_H  = 7;
  localparam int B_LSB_L  = 0;
  localparam int B_2W_H   = 6;
  localparam int B_2W_L   = 1;
  localparam int B_51_H   = 5;
  localparam int B_51_L   = 2;
  ////////////////////////////////////////////////////////////////////////////////
  // bit count and conversion length in conversion clock periods
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [4:0] CONV_CCLKS = 5'h10;
  // serial interface states
  typedef enum logic [4:0] {
    ST_OFF  = 5'b00001,
    ST_HUNT = 5'b00010,
    ST_CMD  = 5'b00100,
    ST_WR   = 5'b01000,
    ST_RD   = 5'b10000
  } daqsp_state_type;
endpackage

// *** src/daqsp_sync.sv ***
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes inputs are asynchronous to i_clk; output moves once stages two and three agree.
*/
`timescale 1ns/10ps
`default_nettype none
module daqsp_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // pins and filtered levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  // first stage feeds only the second; filter looks at stages two and three
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q    <= RV;
      s2_q    <= RV;
      s3_q    <= RV;
      o_level <= RV;
    end else begin
      s1_q    <= i_async;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      o_level <= (agree & s3_q) | (~agree & o_level);
    end
  end

  a_level_agree: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ((o_level ^ $past(o_level)) & ~$past(agree)) == {W{1'b0}})
    else $error("filtered level moved without agreement");
endmodule // daqsp_sync
`default_nettype wire

// *** src/daqsp_port.sv ***
/*
  Serial command and register port of the acquisition converter, with control
  registers and conversion sequencing. Assumes the host is the serial master and
  that the analog core supplies a result when a conversion ends.
*/
// Summary of operation
// RL1 - 8-bit write to address 0 resets device
// RL2 - every reset zeroes registers, stops osc, reference; chip select high zeroes none of them
// RL3 - reset write acts right after instruction byte
// RL4 - chip select high resets only serial logic
// RL5 - after reset write, next 1 resynchronises
// RL6 - host resyncs with thirty-nine zeros then one
// RL7 - eight instruction bits on active edges, pin-selected
// RL8 - host holds chip select low whole transfer
// RL9 - convert bit starts conversion on second fall
// RL10 - convert bit reads back conversion in progress
// RL11 - 16-bit write commits both bytes together
// RL12 - second byte address is address xor one
// RL13 - read data starts on next inactive edge
// RL14 - data moves on inactive edges; shared pin released
// RL15 - serial output floats only with select high
// RL16 - read captures state; then await new instruction
// RL17 - result registers hold low/high bits, overrange
// RL18 - conversion control: binary, readback, divider, test
// RL19 - pin direction and pin state registers
// RL20 - reference/oscillator register switches and level
// RL21 - serial config: bit order, wires, 8051
// RL22 - channel bits drive multiplexer, D2 polarity
// RL23 - direct instruction starts conversion, loads gain/channel
// RL24 - register instruction: read, width, address fields
// RL25 - top channel bit picks differential/single-ended
`timescale 1ns/10ps
`default_nettype none
module daqsp_port
  import daqsp_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5a // arbitrary identification value
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_din,
  input  wire logic        i_edge_rise,
  output logic             o_din,
  output logic             o_din_oe,
  output logic             o_dout,
  output logic             o_dout_oe,
  // general purpose pins
  input  wire logic [3:0]  i_pin,
  output logic      [3:0]  o_pin,
  output logic      [3:0]  o_pin_oe,
  // analog core
  input  wire logic [13:0] i_conv_data,
  input  wire logic        i_overrange,
  input  wire logic [5:0]  i_fault_detail,
  output logic             o_conversion_clock_out,
  output logic             o_conv_start,
  output logic             o_conv_busy,
  output logic      [3:0]  o_channel_select,
  output logic      [2:0]  o_gain_select,
  output logic             o_oscillator_on,
  output logic             o_reference_on,
  output logic             o_reference_buffer_on,
  output logic      [1:0]  o_ref_level
);
  import daqsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [3:0] pin_lv;
  logic [3:0] gpin_lv;
  daqsp_sync #(.W(4), .RV(4'h2)) u_sync_ser (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async ({i_edge_rise, i_din, i_cs_n, i_sclk}),
    .o_level (pin_lv)
  );
  daqsp_sync #(.W(4), .RV(4'h0)) u_sync_pin (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (i_pin),
    .o_level (gpin_lv)
  );

  daqsp_state_type st_q;
  logic       sclk_q;
  logic [2:0] bit_q;
  logic [7:0] rx_q;
  logic [7:0] b1_q;
  logic [7:0] tx_q;
  logic [4:0] addr_q;
  logic       wide_q;
  logic       second_q;
  logic       rel_q;
  logic [7:0] ctl_q;
  logic [7:0] gmx_q;
  logic [7:0] pst_q;
  logic [7:0] dir_q;
  logic [7:0] ref_q;
  logic [2:0] ser_q;
  logic [7:0] res_lo_q;
  logic [7:0] res_hi_q;
  logic [7:0] vld_q;
  logic [7:0] cdiv_q;
  logic       pend_q;
  logic       pfall_q;
  logic       busy_q;
  logic [4:0] ccnt_q;

  // active edge polarity follows the edge pin; edges ignored while deselected
  wire sclk_lv  = pin_lv[0];
  wire cs_lv    = pin_lv[1];
  wire din_lv   = pin_lv[2];
  wire rise_sel = pin_lv[3];
  wire sclk_chg = (sclk_lv != sclk_q) && !cs_lv;
  wire act_ev   = sclk_chg && (sclk_lv == rise_sel);       // RL7
  wire inact_ev = sclk_chg && (sclk_lv != rise_sel);
  wire lsb_1st  = ser_q[0];
  wire two_wire = ser_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // instruction and data decode
  wire [7:0] rx_nx    = lsb_1st ? {din_lv, rx_q[7:1]} : {rx_q[6:0], din_lv};
  wire       byte_end = act_ev && (bit_q == LAST_BIT);
  wire       cmd_done = (st_q == ST_CMD) && byte_end;      // RL7
  wire       direct   = rx_nx[B_DIRECT];                   // RL24
  wire [4:0] addr_nx  = rx_nx[B_ADR_HI:0];
  wire       rst_wr   = cmd_done && !direct && !rx_nx[B_RD]
                        && !rx_nx[B_WIDE] && (addr_nx == A_RES_LO); // RL1 RL3
  wire       dir_cmd  = cmd_done && direct;                // RL23
  wire       rd_cmd   = cmd_done && !direct && rx_nx[B_RD];
  wire       wr_cmd   = cmd_done && !direct && !rx_nx[B_RD] && !rst_wr;
  wire       wr_end   = (st_q == ST_WR) && byte_end;
  wire       commit   = wr_end && (!wide_q || second_q);   // RL11
  wire       rd_end   = (st_q == ST_RD) && byte_end;
  wire [4:0] pair     = {addr_q[4:1], ~addr_q[0]};         // RL12
  wire [7:0] wd_a     = wide_q ? b1_q : rx_nx;
  wire       w1       = commit;
  wire       w2       = commit && wide_q;
  wire       busy_any = pend_q || busy_q;

  // a commit hits the first address with byte one and the pair with byte two
  function automatic logic [1:0] hit(input logic [4:0] a);
    hit = {w2 && (pair == a), w1 && (addr_q == a)};
  endfunction

  wire [1:0] h_ctl = hit(A_CTL);
  wire [1:0] h_gmx = hit(A_GMX);
  wire [1:0] h_pst = hit(A_PST);
  wire [1:0] h_dir = hit(A_DIR);
  wire [1:0] h_ref = hit(A_REF);
  wire [1:0] h_ser = hit(A_SER);
  wire       go_wr = (h_gmx[0] && wd_a[B_BUSY]) || (h_gmx[1] && rx_nx[B_BUSY])
                     || (h_pst[0] && wd_a[B_BUSY]) || (h_pst[1] && rx_nx[B_BUSY]); // RL9
  wire       conv_go = go_wr || dir_cmd;                   // RL23
  wire [7:0] ser_wd  = h_ser[0] ? wd_a : rx_nx;

  ////////////////////////////////////////////////////////////////////////////////
  // read multiplexer; pins set as inputs show their sampled level
  wire [3:0] pin_rd = (dir_q[3:0] & pst_q[3:0]) | (~dir_q[3:0] & gpin_lv); // RL19
  wire [7:0] ser_rd = {ser_q[0], ser_q[1], ser_q[2], 2'h0, ser_q[2], ser_q[1], ser_q[0]};
  wire [7:0] hi_rd  = res_hi_q ^ {ctl_q[B_BIN], 7'h00};   // RL18

  function automatic logic [7:0] rmux(input logic [4:0] a);
    unique case (a)
      A_RES_LO: rmux = res_lo_q;
      A_RES_HI: rmux = hi_rd;
      A_FAULT:  rmux = vld_q;
      A_CTL:    rmux = ctl_q;
      A_GMX:    rmux = {busy_any, gmx_q[6:0]};             // RL10
      A_PST:    rmux = {busy_any, 3'h0, pin_rd};           // RL10
      A_DIR:    rmux = dir_q;
      A_REF:    rmux = ref_q;
      A_SER:    rmux = ser_rd;
      A_ID:     rmux = ID_CODE;
      default:  rmux = REG_RST;
    endcase
  endfunction

  wire [2:0] obit  = lsb_1st ? bit_q : 3'(LAST_BIT - bit_q);
  wire       tx_bit = tx_q[obit];

  ////////////////////////////////////////////////////////////////////////////////
  // serial state machine; chip select high parks it without touching registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ST_OFF;
      sclk_q <= 1'b0;
      bit_q <= 3'h0;
      rx_q <= REG_RST;
      b1_q <= REG_RST;
      tx_q <= REG_RST;
      addr_q <= 5'h00;
      wide_q <= 1'b0;
      second_q <= 1'b0;
    end else begin
      sclk_q <= sclk_lv;
      if (cs_lv) begin
        st_q <= ST_OFF;                                    // RL4
        bit_q <= 3'h0;
        second_q <= 1'b0;
      end else begin
        if (act_ev) begin
          rx_q <= rx_nx;
          bit_q <= 3'(bit_q + 3'h1);
        end
        unique case (st_q)
          ST_OFF: begin
            st_q <= ST_CMD;
            bit_q <= 3'h0;
          end
          ST_HUNT: begin
            bit_q <= 3'h0;
            if (act_ev && din_lv) st_q <= ST_CMD;          // RL5
          end
          ST_CMD: begin
            if (rst_wr) st_q <= ST_HUNT;                   // RL3 RL5
            else if (wr_cmd) st_q <= ST_WR;
            else if (rd_cmd) begin
              st_q <= ST_RD;
              tx_q <= rmux(addr_nx);                       // RL16
            end
            if (cmd_done) begin
              addr_q <= addr_nx;
              wide_q <= rx_nx[B_WIDE];                     // RL24
              second_q <= 1'b0;
            end
          end
          ST_WR: begin
            if (wr_end && !commit) begin
              b1_q <= rx_nx;
              second_q <= 1'b1;
            end else if (commit) st_q <= ST_CMD;
          end
          ST_RD: begin
            if (rd_end && wide_q && !second_q) begin
              tx_q <= rmux(pair);                          // RL12 RL16
              second_q <= 1'b1;
            end else if (rd_end) st_q <= ST_CMD;           // RL16
          end
        endcase
      end
    end
  end

  // read data moves on inactive edges; the shared pin lets go one edge after the end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dout <= 1'b0;
      o_dout_oe <= 1'b0;
      o_din <= 1'b0;
      o_din_oe <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      o_dout_oe <= !cs_lv;                                 // RL15
      if (cs_lv) begin
        o_dout <= 1'b0;
        o_din_oe <= 1'b0;
        rel_q <= 1'b0;
      end else if (inact_ev) begin
        if (st_q == ST_RD) begin
          o_dout <= tx_bit;                                // RL13 RL14
          o_din <= tx_bit;
          o_din_oe <= two_wire;                            // RL13
        end else if (rel_q) begin
          o_din_oe <= 1'b0;                                // RL14
          rel_q <= 1'b0;
        end
      end else if (rd_end && (second_q || !wide_q)) rel_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers; both bytes of a pair land on the same edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_q <= REG_RST;
      gmx_q <= REG_RST;
      pst_q <= REG_RST;
      dir_q <= REG_RST;
      ref_q <= REG_RST;
      ser_q <= 3'h0;
    end else if (rst_wr) begin
      ctl_q <= REG_RST;                                    // RL1 RL2
      gmx_q <= REG_RST;
      pst_q <= REG_RST;
      dir_q <= REG_RST;
      ref_q <= REG_RST;
      ser_q <= 3'h0;
    end else begin
      if (h_ctl[0]) ctl_q <= wd_a & M_CTL;                 // RL11 RL18
      else if (h_ctl[1]) ctl_q <= rx_nx & M_CTL;
      if (dir_cmd) gmx_q <= rx_nx & M_GMX;                 // RL23
      else if (h_gmx[0]) gmx_q <= wd_a & M_GMX;            // RL22
      else if (h_gmx[1]) gmx_q <= rx_nx & M_GMX;
      if (h_pst[0]) pst_q <= wd_a & M_NIB;                 // RL19
      else if (h_pst[1]) pst_q <= rx_nx & M_NIB;
      if (h_dir[0]) dir_q <= wd_a & M_NIB;                 // RL19
      else if (h_dir[1]) dir_q <= rx_nx & M_NIB;
      if (h_ref[0]) ref_q <= wd_a & M_REF;                 // RL20
      else if (h_ref[1]) ref_q <= rx_nx & M_REF;
      if (|h_ser) begin
        ser_q[0] <= ser_wd[B_LSB_H] | ser_wd[B_LSB_L];     // RL21
        ser_q[1] <= ser_wd[B_2W_H] | ser_wd[B_2W_L];
        ser_q[2] <= ser_wd[B_51_H] | ser_wd[B_51_L];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion clock: runs only with the oscillator on, halves per divider step
  wire [7:0] cdiv_lim = 8'((8'h01 << ctl_q[B_CDF_HI:B_CDF_LO]) - 8'h01);
  wire       ctick    = ref_q[B_OSC] && (cdiv_q == cdiv_lim);
  wire       fall_ev  = ctick && o_conversion_clock_out;
  wire       conv_end = busy_q && fall_ev && (ccnt_q == 5'(CONV_CCLKS - 5'h01));

  // start waits for the second falling conversion clock edge after the request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cdiv_q <= 8'h00;
      o_conversion_clock_out <= 1'b0;
      pend_q <= 1'b0;
      pfall_q <= 1'b0;
      busy_q <= 1'b0;
      ccnt_q <= 5'h00;
      o_conv_start <= 1'b0;
    end else if (rst_wr) begin
      cdiv_q <= 8'h00;
      o_conversion_clock_out <= 1'b0;                      // RL2
      pend_q <= 1'b0;
      pfall_q <= 1'b0;
      busy_q <= 1'b0;
      ccnt_q <= 5'h00;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      cdiv_q <= (!ref_q[B_OSC] || ctick) ? 8'h00 : 8'(cdiv_q + 8'h01);
      if (ctick) o_conversion_clock_out <= !o_conversion_clock_out;
      if (conv_go && !busy_any) begin
        pend_q <= 1'b1;
        pfall_q <= 1'b0;
      end else if (pend_q && fall_ev) begin
        if (pfall_q) begin
          pend_q <= 1'b0;                                  // RL9
          busy_q <= 1'b1;
          ccnt_q <= 5'h00;
          o_conv_start <= 1'b1;
        end else pfall_q <= 1'b1;
      end else if (busy_q && fall_ev) begin
        ccnt_q <= 5'(ccnt_q + 5'h01);
        if (conv_end) busy_q <= 1'b0;
      end
    end
  end

  // results: low byte keeps the six low bits, a fixed zero and the overrange flag
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      res_lo_q <= REG_RST;
      res_hi_q <= REG_RST;
      vld_q <= REG_RST;
    end else if (rst_wr) begin
      res_lo_q <= REG_RST;                                 // RL2
      res_hi_q <= REG_RST;
      vld_q <= REG_RST;
    end else if (conv_end) begin
      res_lo_q <= {i_conv_data[5:0], 1'b0, i_overrange};   // RL17
      res_hi_q <= i_conv_data[13:B_MSB_LO];                // RL17
      vld_q <= {2'h0, i_fault_detail};
    end
  end

  // outputs are slices of flops
  assign o_conv_busy = busy_q;
  assign o_channel_select = gmx_q[3:0];                    // RL22 RL25
  assign o_gain_select = gmx_q[6:4];
  assign o_oscillator_on = ref_q[B_OSC];                   // RL20
  assign o_reference_on = ref_q[B_REFERENCE_ON];
  assign o_reference_buffer_on = ref_q[B_REFERENCE_BUFFER_ON];
  assign o_ref_level = ref_q[B_LVL_HI:0];
  assign o_pin = pst_q[3:0];
  assign o_pin_oe = dir_q[3:0];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_req; conv_go && !busy_any; endsequence
  sequence s_second_fall; pend_q && pfall_q && fall_ev && !rst_wr; endsequence

  a_reset_clears: assert property (rst_wr |=> (ctl_q == REG_RST) && (ref_q == REG_RST)
    && (gmx_q == REG_RST) && (ser_q == 3'h0)) // RL1
    else $error("reset write left registers set");
  a_reset_hunts: assert property (rst_wr && !cs_lv |=> st_q == ST_HUNT) // RL3
    else $error("reset write did not enter hunt");
  a_cs_parks: assert property (cs_lv |=> st_q == ST_OFF && !o_din_oe) // RL4
    else $error("chip select high did not park port");
  a_hunt_sync: assert property (st_q == ST_HUNT && act_ev && din_lv && !cs_lv
    |=> st_q == ST_CMD && bit_q == 3'h0) // RL5
    else $error("sync bit missed");
  a_start_fall: assert property (o_conv_start |-> $past(fall_ev) && $past(pend_q)
    && $past(pfall_q)) // RL9
    else $error("conversion start not on second fall");
  a_req_pends: assert property (s_req |=> pend_q) // RL9
    else $error("conversion request not held pending");
  a_second_fall: assert property (s_second_fall |=> o_conv_start && busy_q) // RL9
    else $error("second fall did not start conversion");
  a_busy_read: assert property (rd_cmd && addr_nx == A_GMX
    |=> tx_q[B_BUSY] == $past(busy_any)) // RL10
    else $error("busy bit wrong in read data");
  a_pair_commit: assert property (commit && wide_q && addr_q == A_GMX && !rst_wr
    |=> gmx_q == ($past(b1_q) & M_GMX) && pst_q == ($past(rx_nx) & M_NIB)) // RL11
    else $error("paired write not committed together");
  a_dout_inact: assert property ($changed(o_dout) && !$past(cs_lv) |-> $past(inact_ev)) // RL14
    else $error("read data moved off inactive edge");
  a_dout_drive: assert property ($rose(cs_lv) |=> !o_dout_oe ##1 !o_dout_oe || !cs_lv) // RL15
    else $error("serial output driven while deselected");
  a_direct_load: assert property (dir_cmd && !cs_lv |=> gmx_q[6:0] == $past(rx_nx[6:0])) // RL23
    else $error("direct instruction did not load gain and channel");
endmodule // daqsp_port
`default_nettype wire

// *** verif/daqsp_host.sv ***
/*
  Host serial master model: frames, instruction and data bits, read capture.
  Assumes rising sclk is the active edge and the host clock is i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module daqsp_host (
  // clock and device side
  input  wire logic i_clk,
  input  wire logic i_dout,
  input  wire logic i_dout_oe,
  // serial pins driven by the host
  output var logic  o_sclk,
  output var logic  o_cs_n,
  output var logic  o_din
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one bit: data moves while sclk is low, long phases so the pin filter sees each edge
  task automatic shift(input logic b, output logic got);
    @(negedge i_clk);
    o_sclk = 1'b0;
    o_din  = b;
    repeat (7) @(negedge i_clk);
    got    = i_dout;
    o_sclk = 1'b1;
    repeat (5) @(negedge i_clk);
  endtask
  // frame: optional zeros and a one, instruction byte, then nb data bits msb first
  task automatic xfer(input int nz, input logic [7:0] ins, input int nb,
                      input logic [15:0] wd, output logic [15:0] rd, output logic oe);
    logic g;
    rd = '0;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (8) @(negedge i_clk);
    oe = i_dout_oe;
    for (int i = 0; i < nz; i++) shift(1'b0, g);
    if (nz > 0) shift(1'b1, g);
    for (int i = 7; i >= 0; i--) shift(ins[i], g);
    for (int i = nb - 1; i >= 0; i--) begin
      shift(wd[i], g);
      rd = {rd[14:0], g};
    end
    @(negedge i_clk);
    o_sclk = 1'b0;
    repeat (7) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_din  = ~o_din; // a released line shows no stale value
    repeat (8) @(negedge i_clk);
  endtask
endmodule // daqsp_host
`default_nettype wire

// *** verif/tb_daqsp_port.sv ***
/*
  Self-checking bench for the serial register port, driven through the host model.
  Assumes the analog core inputs hold fixed values during the run.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_daqsp_port;
  import daqsp_pkg::*;
  localparam logic [13:0] CONV = 14'h2a5c;
  localparam logic [5:0]  FLT  = 6'h2d;
  logic        clk, nrst, sclk, cs_n, din, dout, dout_oe, busy, osc_on, oe;
  logic        edge_rise, din_oe;
  logic        din_oe_seen = 1'b0;
  logic [3:0]  pin_oe, ch;
  logic [2:0]  gain;
  logic [15:0] rd;
  int          mismatches = 0;
  int          n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // id value is arbitrary
  daqsp_port #(.ID_CODE(8'h3c)) DUT (
    .i_clk(clk), .i_nrst(nrst), .i_sclk(sclk ^ !edge_rise), .i_cs_n(cs_n), .i_din(din),
    .i_edge_rise(edge_rise), .o_din(), .o_din_oe(din_oe), .o_dout(dout), .o_dout_oe(dout_oe),
    .i_pin(4'h0), .o_pin(), .o_pin_oe(pin_oe), .i_conv_data(CONV), .i_overrange(1'b1),
    .i_fault_detail(FLT), .o_conversion_clock_out(), .o_conv_start(), .o_conv_busy(busy),
    .o_channel_select(ch), .o_gain_select(gain), .o_oscillator_on(osc_on),
    .o_reference_on(), .o_reference_buffer_on(), .o_ref_level()
  );
  daqsp_host host (
    .i_clk(clk), .i_dout(dout), .i_dout_oe(dout_oe), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // clock, frame shorthand and run end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic t(input int nz, input logic [7:0] ins, input int nb, input logic [15:0] wd);
    host.xfer(nz, ins, nb, wd, rd, oe);
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the sequence needs roughly 6700 clocks
  initial begin
    #2_000_000;
    mismatches++;
    conclude();
  end
  // shared pin drive is brief, so remember whether it was ever seen
  always @(negedge clk) if (din_oe === 1'b1) din_oe_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    edge_rise = 1'b1;
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t(0, {3'b010, A_ID}, 8, 16'h0);
    `CHK(rd[7:0], 8'h3c)
    `CHK(oe, 1'b1)
    `CHK(dout_oe, 1'b0)
    // falling active edge: the device sees the host clock inverted
    edge_rise = 1'b0;
    t(0, {3'b010, A_ID}, 8, 16'h0);
    `CHK(rd[7:0], 8'h3c)
    edge_rise = 1'b1;
    t(0, {3'b000, A_CTL}, 8, 16'h00ff);
    t(0, {3'b010, A_CTL}, 8, 16'h0);
    `CHK(rd[7:0], 8'hff & M_CTL)
    t(0, {3'b001, A_DIR}, 16, 16'h0a1f);
    `CHK(pin_oe, 4'ha)
    `CHK(osc_on, 1'b1)
    t(0, {3'b011, A_REF}, 16, 16'h0);
    `CHK(rd, {8'h1f & M_REF, 8'h0a})
    t(0, {3'b000, A_DIR}, 4, 16'h0005);
    `CHK(pin_oe, 4'ha)
    // lsb first and two-wire; host sends bit-reversed bytes
    t(0, {3'b000, A_SER}, 8, 16'h00c3);
    t(0, 8'h60, 8, 16'h00a0);
    `CHK(pin_oe, 4'h5)
    t(0, 8'h62, 8, 16'h0);
    `CHK(rd[7:0], 8'ha0)
    `CHK(din_oe_seen, 1'b1)
    `CHK(din_oe, 1'b0)
    // reset write inside the frame, then the marker one and a read
    t(8, {3'b010, A_CTL}, 8, 16'h0);
    `CHK(rd[7:0], 8'h00)
    `CHK(osc_on, 1'b0)
    `CHK(pin_oe, 4'h0)
    t(0, {3'b000, A_DIR}, 8, 16'h0003);
    t(0, {3'b000, A_RES_LO}, 0, 16'h0);
    `CHK(pin_oe, 4'h0)
    t(0, {3'b000, A_DIR}, 8, 16'h0006);
    t(39, {3'b010, A_DIR}, 8, 16'h0);
    `CHK(rd[7:0], 8'h00)
    // paired write to gain/channel and pin state, convert bit clear
    t(0, {3'b001, A_GMX}, 16, 16'h2503);
    `CHK(ch, 4'h5)
    `CHK(gain, 3'h2)
    // slow conversion clock so busy can be seen on a read
    t(0, {3'b000, A_CTL}, 8, 16'h0003);
    t(0, {3'b000, A_REF}, 8, 16'h0010);
    t(0, 8'hb9, 0, 16'h0);
    `CHK(gain, 3'h3)
    `CHK(ch, 4'h9)
    t(0, {3'b010, A_GMX}, 8, 16'h0);
    `CHK(rd[7:0], 8'hb9)
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clk);
    `CHK(busy, 1'b0)
    t(0, {3'b011, A_RES_HI}, 16, 16'h0);
    `CHK(rd, {CONV[13:6], CONV[5:0], 1'b0, 1'b1})
    t(0, {3'b011, A_FAULT}, 16, 16'h0);
    `CHK(rd, {2'b00, FLT, 8'h03})
    t(0, {3'b011, A_GMX}, 16, 16'h0);
    `CHK(rd, 16'h3900)
    // convert bit written through the pin state register
    t(0, {3'b000, A_PST}, 8, 16'h0080);
    for (int k = 0; k < 200 && busy !== 1'b1; k++) @(negedge clk);
    `CHK(busy, 1'b1)
    conclude();
  end
endmodule // tb_daqsp_port
`default_nettype wire
